// file: design/two_channel_pulse_width_modulator.sv
// two-channel pulse width modulator with register port and interrupt
//
// Summary of operation
// - the period stays fixed at the configured value, or at 5 ms for a setting of 1 to 4 ms, and only the on time varies with the value.
// - the 12-bit value scales linearly, 0 giving 0% and 4095 giving 100% of the period.
// - a zero value, or an on time below the minimum on time, keeps the output low.
// - the period is set in milliseconds and a period of zero suppresses all pulses.
// - the period setting accepts 0 to 65535 milliseconds.
// - no period shorter than 5 ms is produced, so the output never exceeds 200 Hz.
// - the minimum on time is in milliseconds, with zero giving a floor of 0.1 ms.
// - with enable evaluation selected, enable high runs the channel and enable low forces it low.
// - with enable evaluation cleared the channel runs always and ignores enable.
// - exactly two channels exist, the first wired to the first output, the second to the second.
// - a claimed hardware output follows the modulator and overrides the program's request.
// - an off time below the minimum off time keeps the output high for the whole period.
// - the minimum off time is 100 microseconds.
// - an error flag is high while on or off time falls below its minimum, whatever enable says.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps

module two_channel_pulse_width_modulator
	import pwm_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEFAULT
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire bus_req_type busReq,
	output logic [31:0] rdData,
	input wire logic programOutFirst,
	input wire logic programOutSecond,
	output logic channelOutFirst,
	output logic channelOutSecond,
	output logic hwOutputFirst,
	output logic hwOutputSecond,
	output logic [1:0] durationLimitError,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// arithmetic helpers

	function automatic logic [31:0] periodCycles(input logic [15:0] ms);
		logic [15:0] eff;
		eff = ms;
		if (ms != 16'h0000 && ms < 16'(MIN_PERIOD_MS))
		begin
			eff = 16'(MIN_PERIOD_MS);
		end
		return 32'(eff) * 32'(MS_CYCLES);
	endfunction

	function automatic logic [31:0] onCycles(input logic [31:0] per, input logic [11:0] val);
		logic [43:0] prod;
		prod = 44'(per) * 44'(val);
		return 32'(prod / 44'(FULL_SCALE));
	endfunction

	function automatic logic [31:0] minOnCycles(input logic [15:0] ms);
		logic [31:0] res;
		res = 32'(ms) * 32'(MS_CYCLES);
		if (ms == 16'h0000)
		begin
			res = 32'(MIN_PULSE_CYCLES);
		end
		return res;
	endfunction

	function automatic logic isAddr(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers

	chan_cfg_type cfgReg [NUM_CHANNELS];
	logic [3:0] irqStatusReg;
	logic [3:0] irqMaskReg;
	logic [31:0] cntReg [NUM_CHANNELS];
	logic [31:0] perLenReg [NUM_CHANNELS];
	logic [31:0] onLenReg [NUM_CHANNELS];
	logic [1:0] outReg;
	logic [1:0] hwReg;
	logic [1:0] errReg;
	logic [31:0] rdDataReg;

	logic [31:0] perNext [NUM_CHANNELS];
	logic [31:0] onNext [NUM_CHANNELS];
	logic [1:0] boundary;
	logic [1:0] errNow;
	logic [1:0] run;
	logic [1:0] outNext;
	logic [1:0] programOut;
	logic [3:0] irqEvents;

	assign programOut = {programOutSecond, programOutFirst};

	////////////////////////////////////////////////////////////////////////////////
	// per-channel timing decisions

	always_comb
	begin
		logic [31:0] rawOn;
		logic [31:0] offLen;
		logic onShort;
		logic offShort;
		rawOn = '0;
		offLen = '0;
		onShort = 1'b0;
		offShort = 1'b0;
		for (int c = 0; c < NUM_CHANNELS; c++)
		begin
			perNext[c] = periodCycles(cfgReg[c].periodMs);
			rawOn = onCycles(perNext[c], cfgReg[c].value);
			offLen = perNext[c] - rawOn;
			onShort = cfgReg[c].value != 12'h000 && rawOn < minOnCycles(cfgReg[c].minOnMs);
			offShort = offLen != 32'h0 && offLen < 32'(MIN_PULSE_CYCLES);
			errNow[c] = perNext[c] != 32'h0 && (onShort || offShort);
			if (perNext[c] == 32'h0 || cfgReg[c].value == 12'h000 || onShort)
			begin
				onNext[c] = 32'h0;
			end
			else if (offShort)
			begin
				onNext[c] = perNext[c];
			end
			else
			begin
				onNext[c] = rawOn;
			end
			boundary[c] = perLenReg[c] == 32'h0 || cntReg[c] == perLenReg[c] - 32'h1;
			run[c] = !cfgReg[c].enEval || cfgReg[c].enable;
			if (!run[c])
			begin
				outNext[c] = 1'b0;
			end
			else if (boundary[c])
			begin
				outNext[c] = onNext[c] != 32'h0;
			end
			else
			begin
				outNext[c] = cntReg[c] + 32'h1 < onLenReg[c];
			end
			irqEvents[IRQ_ERR_LSB + c] = errNow[c] && !errReg[c];
			irqEvents[IRQ_PERIOD_LSB + c] = boundary[c] && perNext[c] != 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// period counters, sampled at each boundary

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int c = 0; c < NUM_CHANNELS; c++)
			begin
				cntReg[c] <= '0;
				perLenReg[c] <= '0;
				onLenReg[c] <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < NUM_CHANNELS; c++)
			begin
				if (boundary[c])
				begin
					cntReg[c] <= '0;
					perLenReg[c] <= perNext[c];
					onLenReg[c] <= onNext[c];
				end
				else
				begin
					cntReg[c] <= cntReg[c] + 32'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs: channel, hardware output override, error flags

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			outReg <= '0;
			hwReg <= '0;
			errReg <= '0;
		end
		else
		begin
			outReg <= outNext;
			errReg <= errNow;
			for (int c = 0; c < NUM_CHANNELS; c++)
			begin
				hwReg[c] <= cfgReg[c].claim ? outNext[c] : programOut[c];
			end
		end
	end

	assign channelOutFirst = outReg[0];
	assign channelOutSecond = outReg[1];
	assign hwOutputFirst = hwReg[0];
	assign hwOutputSecond = hwReg[1];
	assign durationLimitError = errReg;

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int c = 0; c < NUM_CHANNELS; c++)
			begin
				cfgReg[c] <= CFG_RESET;
			end
			irqMaskReg <= IRQ_RESET;
		end
		else if (busReq.wrStrobe)
		begin
			for (int c = 0; c < NUM_CHANNELS; c++)
			begin
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + CTRL_OFS))
				begin
					cfgReg[c].claim <= busReq.wrData[CTRL_CLAIM_BIT];
					cfgReg[c].enEval <= busReq.wrData[CTRL_EVAL_BIT];
					cfgReg[c].enable <= busReq.wrData[CTRL_ENABLE_BIT];
				end
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + VALUE_OFS))
				begin
					cfgReg[c].value <= busReq.wrData[11:0];
				end
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + PERIOD_OFS))
				begin
					cfgReg[c].periodMs <= busReq.wrData[15:0];
				end
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + MINON_OFS))
				begin
					cfgReg[c].minOnMs <= busReq.wrData[15:0];
				end
			end
			if (isAddr(busReq.addr, IRQ_MASK_OFS))
			begin
				irqMaskReg <= busReq.wrData[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky interrupt status: set wins over write-one-to-clear

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irqStatusReg <= IRQ_RESET;
		end
		else
		begin
			logic [3:0] clr;
			clr = (busReq.wrStrobe && isAddr(busReq.addr, IRQ_STATUS_OFS)) ? busReq.wrData[3:0] : 4'h0;
			irqStatusReg <= (irqStatusReg & ~clr) | irqEvents;
		end
	end

	assign irq = |(irqStatusReg & irqMaskReg);

	////////////////////////////////////////////////////////////////////////////////
	// register reads, data one cycle after the strobe

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdDataReg <= '0;
		end
		else if (busReq.rdStrobe)
		begin
			logic [31:0] data;
			data = 32'h0;
			for (int c = 0; c < NUM_CHANNELS; c++)
			begin
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + CTRL_OFS))
				begin
					data = {29'h0, cfgReg[c].enable, cfgReg[c].enEval, cfgReg[c].claim};
				end
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + VALUE_OFS))
				begin
					data = {20'h0, cfgReg[c].value};
				end
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + PERIOD_OFS))
				begin
					data = {16'h0, cfgReg[c].periodMs};
				end
				if (isAddr(busReq.addr, 8'(c) * CH_STRIDE + MINON_OFS))
				begin
					data = {16'h0, cfgReg[c].minOnMs};
				end
			end
			if (isAddr(busReq.addr, ERR_STATUS_OFS))
			begin
				data = {28'h0, hwReg, errReg};
			end
			if (isAddr(busReq.addr, IRQ_STATUS_OFS))
			begin
				data = {28'h0, irqStatusReg};
			end
			if (isAddr(busReq.addr, IRQ_MASK_OFS))
			begin
				data = {28'h0, irqMaskReg};
			end
			rdDataReg <= data;
		end
		else
		begin
			rdDataReg <= '0;
		end
	end

	assign rdData = rdDataReg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	zero_on_low_a: assert property (onLenReg[0] == 32'h0 && !boundary[0] |=> !outReg[0])
		else $error("channel high with zero on length");
	enable_gate_a: assert property (cfgReg[0].enEval && !cfgReg[0].enable |=> !outReg[0])
		else $error("channel high while disabled");
	enable_ignored_a: assert property (!cfgReg[0].enEval && perLenReg[0] != 32'h0
		&& onLenReg[0] == perLenReg[0] && !boundary[0] |=> outReg[0])
		else $error("enable not ignored with evaluation off");
	period_start_a: assert property (boundary[0] && run[0] && onNext[0] != 32'h0
		|=> outReg[0] && cntReg[0] == 32'h0)
		else $error("period did not start high");
	period_floor_a: assert property (perLenReg[0] != 32'h0
		|-> perLenReg[0] >= 32'(MIN_PERIOD_MS) * 32'(MS_CYCLES))
		else $error("period below five milliseconds");
	zero_period_a: assert property (cfgReg[0].periodMs == 16'h0 && boundary[0]
		|=> perLenReg[0] == 32'h0 && !outReg[0])
		else $error("pulses with zero period");
	on_within_a: assert property (boundary[0] |=> onLenReg[0] <= perLenReg[0])
		else $error("on length beyond period");
	error_flag_a: assert property (errNow[1] |=> durationLimitError[1])
		else $error("error flag missing");
	override_a: assert property (cfgReg[1].claim |=> hwOutputSecond == channelOutSecond)
		else $error("claimed output not driven by channel");
	release_a: assert property (!cfgReg[0].claim |=> hwOutputFirst == $past(programOutFirst))
		else $error("unclaimed output not following program");
	irq_sticky_a: assert property (irqStatusReg[0] && irqMaskReg[0] && !busReq.wrStrobe |=> irq)
		else $error("unmasked status bit lost");

	pulse_rise_c: cover property (!outReg[0] ##1 outReg[0]);
	full_on_c: cover property (boundary[0] && onNext[0] == perNext[0] && perNext[0] != 32'h0);
	error_seen_c: cover property (durationLimitError[0]);
	irq_seen_c: cover property (irq);

endmodule

// file: shared/pwm_pkg.sv
// constants, register map and carrier types of the two-channel pulse width modulator
package pwm_pkg;

	localparam int CLK_PERIOD_NS = 100;
	localparam int NUM_CHANNELS = 2;

	// time base figures in their own units
	localparam int MIN_PULSE_US = 100;
	localparam int MS_NS = 1000000;
	localparam int MIN_PERIOD_MS = 5;
	localparam int MIN_PULSE_CYCLES = (MIN_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_CYCLES_DEFAULT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int VALUE_WIDTH = 12;
	localparam int MS_WIDTH = 16;
	localparam int CYC_WIDTH = 32;
	localparam logic [11:0] FULL_SCALE = 12'hFFF;

	// register map, byte addresses
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] VALUE_OFS = 8'h04;
	localparam logic [7:0] PERIOD_OFS = 8'h08;
	localparam logic [7:0] MINON_OFS = 8'h0C;
	localparam logic [7:0] ERR_STATUS_OFS = 8'h20;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h24;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h28;

	// control register fields
	localparam int CTRL_CLAIM_BIT = 0;
	localparam int CTRL_EVAL_BIT = 1;
	localparam int CTRL_ENABLE_BIT = 2;

	// interrupt status fields: error bit n and period bit n+2 = channel n
	localparam int IRQ_ERR_LSB = 0;
	localparam int IRQ_PERIOD_LSB = 2;
	localparam int IRQ_WIDTH = 4;
	localparam logic [3:0] IRQ_RESET = 4'h0;

	typedef struct packed {
		logic claim;
		logic enEval;
		logic enable;
		logic [11:0] value;
		logic [15:0] periodMs;
		logic [15:0] minOnMs;
	} chan_cfg_type;

	localparam chan_cfg_type CFG_RESET = '0;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wrData;
		logic wrStrobe;
		logic rdStrobe;
	} bus_req_type;

endpackage

// file: testbench/output_stage_model.sv
// output stage model: the load follows each hardware output
`timescale 1ns/100ps

module output_stage_model
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] drive,
	output logic [1:0] energized
);

	// transistor stage switches on the edge after its drive changes
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			energized <= 2'h0;
		else
			energized <= drive;
	end

endmodule

// file: testbench/tb_top.sv
// self-checking bench of the two-channel pulse width modulator
`timescale 1ns/100ps

module tb_top;
	import pwm_pkg::*;

	localparam int MS = 400;
	// ch, period ms, value, min on ms, ctrl
	localparam int TBL [12][5] = '{'{0, 5, 2048, 1, 1}, '{1, 5, 2048, 1, 1}, '{0, 5, 0, 1, 1},
		'{0, 5, 1000, 0, 1}, '{0, 5, 1000, 1, 1}, '{0, 5, 4095, 1, 1}, '{1, 5, 4090, 1, 1},
		'{0, 0, 2048, 1, 1}, '{0, 2, 2048, 1, 1}, '{0, 5, 2048, 1, 3}, '{0, 5, 2048, 1, 7},
		'{1, 5, 1000, 0, 2}};

	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic progA = 1'b0;
	logic progB = 1'b0;
	logic [1:0] progDly = 2'h0;
	bus_req_type busReq = '0;
	logic [31:0] rdData;
	logic chA, chB, hwA, hwB, irq;
	logic [1:0] dle;
	logic [1:0] load;
	int errorCnt = 0;
	int checks = 0;
	int seed = 32'h78B7CE84;

	always #50 clk = ~clk;

	two_channel_pulse_width_modulator #(.MS_CYCLES(MS)) dut(.clk(clk), .rst_b(rst_b),
		.busReq(busReq), .rdData(rdData), .programOutFirst(progA), .programOutSecond(progB),
		.channelOutFirst(chA), .channelOutSecond(chB), .hwOutputFirst(hwA),
		.hwOutputSecond(hwB), .durationLimitError(dle), .irq(irq));

	output_stage_model stage(.clk(clk), .rst_b(rst_b), .drive({hwB, hwA}), .energized(load));

	// program logic keeps requesting random levels on both outputs
	always @(posedge clk)
	begin
		progA <= 1'($random(seed));
		progB <= 1'($random(seed));
		progDly <= {progB, progA};
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		busReq.wrStrobe <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		busReq <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		busReq.rdStrobe <= 1'b0;
		#1 d = rdData;
	endtask

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// reference on length in cycles of one period
	function automatic longint expOn(longint per, longint val, longint me, bit gate,
		output bit err);
		longint pl, on, mn, off;
		pl = (per == 0) ? 0 : ((per < 5) ? 5 : per) * MS;
		mn = (me == 0) ? MIN_PULSE_CYCLES : me * MS;
		on = pl * val / 4095;
		off = pl - on;
		err = (val != 0 && on < mn) || (off > 0 && off < MIN_PULSE_CYCLES);
		if (on < mn)
			on = 0;
		else if (off > 0 && off < MIN_PULSE_CYCLES)
			on = pl;
		return gate ? on : 0;
	endfunction

	task automatic run(int ch, int per, int val, int me, int ctrl);
		logic [7:0] base;
		logic [31:0] d;
		logic [1:0] q;
		longint on, pl, cnt;
		bit err, hwOk;
		logic [1:0] hwLast;
		base = 8'(ch * 16);
		on = expOn(per, val, me, !ctrl[1] || ctrl[2], err);
		pl = ((per < 5) ? 5 : per) * MS;
		hwOk = 1'b1;
		cnt = 0;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		wr(base + VALUE_OFS, val);
		wr(base + MINON_OFS, me);
		wr(IRQ_MASK_OFS, 1 << ch);
		wr(base + CTRL_OFS, ctrl);
		// period last, so the first boundary latches the whole set
		wr(base + PERIOD_OFS, per);
		repeat (12)
		begin
			@(posedge clk);
			#1 q = {chB, chA};
			if (q[ch] === 1'b1)
				break;
		end
		for (longint k = 0; k < pl; k++)
		begin
			q = {chB, chA};
			cnt += (q[ch] === 1'b1);
			hwLast = {hwB, hwA};
			if (hwLast[ch] !== (ctrl[0] ? q[ch] : progDly[ch]))
				hwOk = 1'b0;
			@(posedge clk);
			#1;
		end
		q = {chB, chA};
		chk("on cycles", 32'(on), 32'(cnt));
		chk("period restart", on != 0, q[ch]);
		chk("hw output", 1, hwOk);
		chk("stage load", 32'(hwLast), 32'(load));
		if (per != 0)
		begin
			chk("error flag", err, dle[ch]);
			rd(ERR_STATUS_OFS, d);
			chk("error status", err, d[ch]);
		end
		rd(base + VALUE_OFS, d);
		chk("value readback", val, d);
		if (err && per != 0)
		begin
			chk("irq raised", 1, irq);
			wr(IRQ_MASK_OFS, 0);
			#1 chk("irq masked", 0, irq);
			wr(IRQ_MASK_OFS, 1 << ch);
			#1 chk("irq unmasked", 1, irq);
			wr(IRQ_STATUS_OFS, 32'hF);
			#1 chk("irq cleared", 0, irq);
		end
		$display("test ch%0d period %0d value %0d ctrl %0d done", ch, per, val, ctrl);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] d;
		foreach (TBL[i])
			run(TBL[i][0], TBL[i][1], TBL[i][2], TBL[i][3], TBL[i][4]);
		repeat (2)
			run(0, 5, 1200 + ($random(seed) & 32'h3FF), 1, 1);
		wr(PERIOD_OFS, 32'hFFFF);
		rd(PERIOD_OFS, d);
		chk("period range", 32'hFFFF, d);
		rd(8'h30, d);
		chk("unmapped read", 0, d);
		$display("register test done");
		wrapUp();
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		errorCnt++;
		wrapUp();
	end

endmodule
